/* File: adc_serial_pkg.sv */
// Shared constants and types for the serial result readout port.
`default_nettype none
package adc_serial_pkg;

  // ----------------------------------------------------------------------
  // Word and buffer geometry
  // ----------------------------------------------------------------------
  localparam int RESULT_BITS = 16;                 // Bits in one conversion result.
  localparam int BUF_DEPTH   = 2;                  // Entries in the result buffer.
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;   // Count after the last result bit.
  localparam logic [4:0] BIT_COUNT_ZERO = 5'h00;   // Count before the first bit.
  localparam logic [4:0] BIT_COUNT_LAST = 5'h0F;   // Count while the last bit is out.
  localparam logic [4:0] BIT_COUNT_STEP = 5'h01;   // Increment per shifted bit.

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 100;         // Core clock period.
  localparam int MASTER_SCLK_HALF_NS = 100;        // Shortest half period of our clock.
  // Half period in core cycles, a least time, so rounded up and at least one.
  localparam int MASTER_HALF_CYCLES_I =
    (MASTER_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] MASTER_HALF_CYCLES =
    (MASTER_HALF_CYCLES_I < 1) ? 8'h01 : MASTER_HALF_CYCLES_I[7:0];
  localparam int SLAVE_SCLK_MAX_MHZ  = 40;         // Host clock ceiling.
  localparam int HOST_SPI_MAX_MBPS   = 17;         // Host SPI master ceiling.

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Pin inputs that cross from outside into the core clock domain.
  typedef struct packed {
    logic sclk;      // Serial clock pin level from the host.
    logic cs_n;      // Chip select, active low.
    logic rd_n;      // Read enable, active low.
    logic casc;      // Read timing select or cascade data in.
    logic ext_clk;   // Clock source select, high for host clock.
    logic serial;    // Port kind select, high for the serial port.
    logic invert;    // Inverts our clock and framing strobe.
  } pins_s;

  // States of the clock generator used when we drive the serial clock.
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_LOW  = 2'b01,
    M_HIGH = 2'b10
  } mstate_e;

endpackage
`default_nettype wire

/* File: adc_pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ns
`default_nettype none
module adc_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  // ----------------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------------
  logic [W-1:0] meta_r;  // First stage, read only by the second stage.

  // Both stages clear to zero; the first is never looked at by logic.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

/* File: adc_result_buf.sv */
// Small valid/ready buffer that carries conversion results to the shifter.
`timescale 1ns/1ns
`default_nettype none
module adc_result_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);

  // ----------------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------------
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = DEPTH[PW:0];
  logic [W-1:0]  mem_r [DEPTH];  // Entry storage.
  logic [PW-1:0] wp_r;           // Write pointer.
  logic [PW-1:0] rp_r;           // Read pointer.
  logic [PW:0]   cnt_r;          // Occupied entries.
  logic [PW:0]   cnt_nxt;        // Next occupancy.
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign cnt_nxt   = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  // Pointers wrap at the depth; ready is registered from the next count.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r     <= '0;
      rp_r     <= '0;
      cnt_r    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      end
      cnt_r    <= cnt_nxt;
      in_ready <= (cnt_nxt != FULL);
    end
  end

  // Entry write, no reset needed on data.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

endmodule
`default_nettype wire

/* File: adc_serial_readout_port.sv */
// Serial result readout port: master and slave shifting of conversion results.
// Notes on behaviour
// - Select low: we generate and drive clock.
// - Master mode drives a data-valid framing strobe.
// - Optional inversion of our clock and strobe.
// - Master: select pin picks after/during conversion.
// - Master after-conversion: busy held until 16 out.
// - Select high: host supplies the shift clock.
// - Slave: clock needs chip select; data needs both.
// - Free-running or gapped host clock, any idle.
// - Slave: 16 bits, MSB first after busy.
// - Host clock sampled by the 100 ns core clock, so at most 5 MHz, not the 40 MHz ceiling.
// - Slave: select pin becomes cascade input.
// - Cascade sampled on edge opposite to shifting.
// - Slave during conversion: previous result shifted out.
// - Slave: unfinished read at conversion end pulses error.
// - Read may straddle into the next conversion.
// - Chip select or read high: data output released.
// - Port works only with serial select high.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_readout_port
  import adc_serial_pkg::*;
#(
  parameter logic [7:0] HALF_CYCLES = MASTER_HALF_CYCLES
) (
  input  wire logic                   CLK,
  input  wire logic                   NRST,
  input  wire logic                   CLOCK_SOURCE_SELECT,
  input  wire logic                   PORT_KIND_SELECT,
  input  wire logic                   READ_TIMING_OR_CASCADE_IN,
  input  wire logic                   CLOCK_INVERT,
  input  wire logic                   CS_N,
  input  wire logic                   RD_N,
  input  wire logic                   SCLK_IN,
  output var  logic                   SCLK_OUT,
  output var  logic                   SCLK_OE_N,
  output var  logic                   SYNC_OUT,
  output var  logic                   SERIAL_RESULT_OUT,
  output var  logic                   SERIAL_RESULT_OE_N,
  output var  logic                   BUSY,
  output var  logic                   INCOMPLETE_READ_FLAG,
  input  wire logic                   CORE_BUSY,
  input  wire logic                   CORE_RESULT_VALID,
  input  wire logic [RESULT_BITS-1:0] CORE_RESULT,
  output var  logic                   CORE_RESULT_READY
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  pins_s pins_raw;   // Raw pin levels packed for the synchroniser.
  pins_s pins_q;     // Pin levels after two flip-flops.

  assign pins_raw = '{sclk:    SCLK_IN,
                      cs_n:    CS_N,
                      rd_n:    RD_N,
                      casc:    READ_TIMING_OR_CASCADE_IN,
                      ext_clk: CLOCK_SOURCE_SELECT,
                      serial:  PORT_KIND_SELECT,
                      invert:  CLOCK_INVERT};

  adc_pin_sync #(
    .W ($bits(pins_s))
  ) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .d    (pins_raw),
    .q    (pins_q)
  );

  // ----------------------------------------------------------------------
  // Mode decode and edge detection
  // ----------------------------------------------------------------------
  logic sclk_prev_r;   // Previous synchronised host clock level.
  logic busy_prev_r;   // Previous conversion busy level.

  wire serial_on  = pins_q.serial;
  wire slave      = serial_on && pins_q.ext_clk;
  wire master     = serial_on && !pins_q.ext_clk;
  wire m_after    = master && !pins_q.casc;
  wire m_during   = master && pins_q.casc;
  wire slave_clk  = slave && !pins_q.cs_n;
  wire sclk_rise  = pins_q.sclk && !sclk_prev_r;
  wire sclk_fall  = !pins_q.sclk && sclk_prev_r;
  wire conv_begin = CORE_BUSY && !busy_prev_r;
  wire conv_end   = !CORE_BUSY && busy_prev_r;
  wire data_en    = serial_on && !pins_q.cs_n && !pins_q.rd_n;

  // Edge history for the host clock and the busy level.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_prev_r <= 1'b0;
      busy_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= pins_q.sclk;
      busy_prev_r <= CORE_BUSY;
    end
  end

  // ----------------------------------------------------------------------
  // Result buffer between the conversion core and the shifter
  // ----------------------------------------------------------------------
  logic                   buf_valid;   // A finished result waits.
  logic [RESULT_BITS-1:0] buf_data;    // The waiting result.
  logic                   load;        // Shifter takes the waiting result.

  adc_result_buf #(
    .W     (RESULT_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (CLK),
    .nrst      (NRST),
    .in_valid  (CORE_RESULT_VALID),
    .in_ready  (CORE_RESULT_READY),
    .in_data   (CORE_RESULT),
    .out_valid (buf_valid),
    .out_ready (load),
    .out_data  (buf_data)
  );

  // ----------------------------------------------------------------------
  // Shifter state
  // ----------------------------------------------------------------------
  logic [RESULT_BITS-1:0] shreg_r;     // Output shift register.
  logic [4:0]             cnt_r;       // Bits shifted out of the current word.
  logic                   casc_r;      // Cascade bit caught on the opposite edge.
  logic                   have_r;      // Loaded word not yet fully read.
  logic                   load_q_r;    // Load happened last cycle.
  mstate_e                m_state_r;   // Clock generator state.
  mstate_e                m_state_nxt; // Next clock generator state.
  logic [7:0]             div_r;       // Half period counter.
  logic                   m_sclk_r;    // Generated clock before inversion.
  logic                   m_sync_r;    // Framing strobe before inversion.

  // A slave read that has begun but not finished blocks a reload.
  wire mid_read  = slave && (cnt_r != BIT_COUNT_ZERO) && (cnt_r < BIT_COUNT_FULL);
  wire rd_err    = slave && conv_end && mid_read;
  wire half_done = (div_r == HALF_CYCLES - 8'h01);
  wire m_start   = (m_after && load_q_r) ||
                   (m_during && conv_begin && have_r);
  wire m_last    = (m_state_r == M_HIGH) && half_done && (cnt_r == BIT_COUNT_LAST);
  wire s_shift   = slave_clk && sclk_fall;
  wire s_sample  = slave_clk && sclk_rise;
  wire m_shift   = (m_state_r == M_HIGH) && half_done;
  wire busy_ext  = m_after && (have_r || buf_valid);

  // The oldest waiting result moves in only when no transfer is in flight.
  assign load = buf_valid && !mid_read && (m_state_r == M_IDLE) && !load_q_r;

  // Clock generator next state: low half, then high half, per bit.
  always_comb begin
    m_state_nxt = m_state_r;
    case (m_state_r)
      M_IDLE: begin
        if (m_start) begin
          m_state_nxt = M_LOW;
        end
      end
      M_LOW: begin
        if (!master) begin
          m_state_nxt = M_IDLE;
        end else if (half_done) begin
          m_state_nxt = M_HIGH;
        end
      end
      M_HIGH: begin
        if (!master || m_last) begin
          m_state_nxt = M_IDLE;
        end else if (half_done) begin
          m_state_nxt = M_LOW;
        end
      end
      default: begin
        m_state_nxt = M_IDLE;
      end
    endcase
  end

  // Clock generator registers: state, divider, clock and strobe levels.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      m_state_r <= M_IDLE;
      div_r     <= 8'h00;
      m_sclk_r  <= 1'b0;
      m_sync_r  <= 1'b0;
    end else begin
      m_state_r <= m_state_nxt;
      div_r     <= (m_state_nxt != m_state_r || m_state_r == M_IDLE) ? 8'h00 : div_r + 8'h01;
      m_sclk_r  <= (m_state_nxt == M_HIGH);
      m_sync_r  <= (m_state_nxt != M_IDLE);
    end
  end

  // Shift register: load a new word, or shift on the active edge.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      shreg_r <= '0;
    end else if (load) begin
      shreg_r <= buf_data;
    end else if (s_shift) begin
      shreg_r <= {shreg_r[RESULT_BITS-2:0], casc_r};
    end else if (m_shift) begin
      shreg_r <= {shreg_r[RESULT_BITS-2:0], 1'b0};
    end
  end

  // Bit counter saturates at a full word so cascaded bits keep flowing.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= BIT_COUNT_ZERO;
    end else if (load || rd_err || m_start) begin
      cnt_r <= BIT_COUNT_ZERO;
    end else if ((s_shift || m_shift) && cnt_r != BIT_COUNT_FULL) begin
      cnt_r <= cnt_r + BIT_COUNT_STEP;
    end
  end

  // Cascade bit, load history and unread-word flag.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      casc_r   <= 1'b0;
      load_q_r <= 1'b0;
      have_r   <= 1'b0;
    end else begin
      if (s_sample) begin
        casc_r <= pins_q.casc;
      end
      load_q_r <= load;
      if (load) begin
        have_r <= 1'b1;
      end else if (rd_err || cnt_r == BIT_COUNT_FULL) begin
        have_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered pin outputs
  // ----------------------------------------------------------------------
  // Every output is a flip-flop; enables are low while we drive.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SCLK_OUT             <= 1'b0;
      SCLK_OE_N            <= 1'b1;
      SYNC_OUT             <= 1'b0;
      SERIAL_RESULT_OUT    <= 1'b0;
      SERIAL_RESULT_OE_N   <= 1'b1;
      BUSY                 <= 1'b0;
      INCOMPLETE_READ_FLAG <= 1'b0;
    end else begin
      SCLK_OUT             <= m_sclk_r ^ pins_q.invert;
      SCLK_OE_N            <= !master;
      SYNC_OUT             <= m_sync_r ^ pins_q.invert;
      SERIAL_RESULT_OUT    <= shreg_r[RESULT_BITS-1];
      SERIAL_RESULT_OE_N   <= !data_en;
      BUSY                 <= CORE_BUSY || busy_ext;
      INCOMPLETE_READ_FLAG <= rd_err;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  AST_MASTER_DRIVES_CLOCK: assert property (
    master |=> !SCLK_OE_N)
    else $error("Clock pin not driven in master mode.");

  AST_STROBE_FRAMES: assert property (
    (m_state_r == M_IDLE && m_start) |=> ##1 (SYNC_OUT != $past(pins_q.invert)))
    else $error("Framing strobe did not open with the transfer.");

  AST_INVERT_IDLE: assert property (
    (m_state_r == M_IDLE && $past(m_state_r) == M_IDLE && $stable(pins_q.invert))
      |=> (SYNC_OUT == $past(pins_q.invert)) && (SCLK_OUT == $past(pins_q.invert)))
    else $error("Idle clock or strobe level ignores inversion.");

  AST_AFTER_START: assert property (
    (m_after && load_q_r && m_state_r == M_IDLE) |=> (m_state_r == M_LOW))
    else $error("After-conversion master transfer did not start.");

  AST_BUSY_HELD: assert property (
    (m_after && have_r) |=> BUSY)
    else $error("Busy dropped before all bits were sent.");

  // Last cycle index of a full transfer: two halves per bit, sixteen bits.
  localparam logic [15:0] M_XFER_LAST = 16'(2 * RESULT_BITS * HALF_CYCLES - 1);
  logic [15:0] m_len_r;  // Cycles spent outside idle in the running transfer.

  // Counts transfer cycles so the length check needs no long repetition.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      m_len_r <= 16'h0000;
    end else if (m_state_r == M_IDLE) begin
      m_len_r <= 16'h0000;
    end else begin
      m_len_r <= m_len_r + 16'h0001;
    end
  end

  AST_MASTER_SIXTEEN: assert property (
    (master && m_last) |-> (m_len_r == M_XFER_LAST))
    else $error("Master transfer length is not sixteen bits.");

  AST_CLOCK_GATED: assert property (
    (slave && pins_q.cs_n && !load && !rd_err) |=> $stable(cnt_r))
    else $error("Host clock counted while chip select high.");

  AST_SLAVE_SHIFT: assert property (
    (s_shift && !load) |=> (shreg_r == {$past(shreg_r[RESULT_BITS-2:0]), $past(casc_r)}))
    else $error("Slave shift lost or reordered a bit.");

  AST_CASCADE_EDGE: assert property (
    s_sample |=> (casc_r == $past(pins_q.casc)))
    else $error("Cascade bit not caught on the opposite edge.");

  AST_READ_ERROR: assert property (
    rd_err |=> INCOMPLETE_READ_FLAG ##1 !INCOMPLETE_READ_FLAG)
    else $error("Read error pulse missing or too long.");

  AST_OUTPUT_RELEASE: assert property (
    (pins_q.cs_n || pins_q.rd_n) |=> SERIAL_RESULT_OE_N)
    else $error("Data output driven with chip select or read high.");

  AST_PARALLEL_QUIET: assert property (
    !pins_q.serial |=> (SCLK_OE_N && SERIAL_RESULT_OE_N))
    else $error("Serial pins active with the parallel port selected.");

  AST_WORD_HELD: assert property (
    (!load && !s_shift && !m_shift) |=> $stable(shreg_r))
    else $error("Shift register changed without a load or shift.");

  COV_MASTER_AFTER: cover property (m_after && m_start);
  COV_MASTER_DURING: cover property (m_during && m_start);
  COV_SLAVE_FULL_WORD: cover property (slave && s_shift && cnt_r == BIT_COUNT_LAST);
  COV_READ_ERROR: cover property (rd_err);

endmodule
`default_nettype wire

/* File: adc_host_model.sv */
// Host serial port model: drives the host clock and selects, captures words.
`timescale 1ns/1ns
`default_nettype none
module adc_host_model (
  input  wire logic clk,
  input  wire logic sclk_pin,
  input  wire logic sdo_pin,
  input  wire logic sync,
  input  wire logic inv,
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic rd_n,
  output var  logic casc
);
  logic [15:0] mq[$];  // Words captured from our master transfers.
  logic [15:0] sh;     // Capture shifter.
  logic        prev;   // Last normalised clock level.
  int          nb;     // Bits captured in the current word.

  // The cascade line is tied low outside chained reads.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    casc = 1'b0;
    sh = '0;
    prev = 1'b0;
    nb = 0;
  end

  // ----------------------------------------------------------------------
  // Master capture
  // ----------------------------------------------------------------------
  // Samples data on each active clock edge while the strobe is active.
  always @(posedge clk) begin
    if (!(sync ^ inv)) begin
      nb = 0;
    end else if ((sclk_pin ^ inv) && !prev) begin
      sh = {sh[14:0], sdo_pin};
      nb++;
      if (nb == 16) begin
        mq.push_back(sh);
        nb = 0;
      end
    end
    prev = sclk_pin ^ inv;
  end

  // Forgets captured words, used after the polarity has settled.
  task automatic clear();
    mq.delete();
    nb = 0;
  endtask

  // Sets chip select and read enable.
  task automatic select(input logic c, input logic r);
    cs_n = c;
    rd_n = r;
  endtask

  // ----------------------------------------------------------------------
  // Slave read
  // ----------------------------------------------------------------------
  // Gapped clock idling low, 800 ns period, far below the rate ceiling.
  // Each bit is taken just before the falling shift edge.
  task automatic slave_read(input int n, input logic [15:0] up, output logic [31:0] got);
    got = '0;
    #37;
    for (int k = 0; k < n; k++) begin
      casc = (k < 16) ? up[15-k] : 1'b0;
      #400 sclk = 1'b1;
      #400 got = {got[30:0], sdo_pin};
      sclk = 1'b0;
    end
    #400 casc = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: adc_serial_readout_port_tb.sv */
// Self-checking bench for the serial result readout port.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_readout_port_tb;
  import adc_serial_pkg::*;
  logic        clk, nrst, src, kind, rdc, inv, cbusy, cvalid, sdo_last, saw_full;
  logic [15:0] cres;
  logic [15:0] w[4];     // Words offered to the port.
  logic [31:0] got;      // Word read back by the host.
  int          failures, n_checks, pulses;
  wire logic   sclk_out, sclk_oe_n, sync, sdo, sdo_oe_n, busy, rderr, cready;
  wire logic   h_sclk, h_cs_n, h_rd_n, h_casc;
  // Shared pins: a released data line shows the inverse of its last bit.
  wire logic   sclk_pin = sclk_oe_n ? h_sclk : sclk_out;
  wire logic   sdo_pin  = sdo_oe_n ? ~sdo_last : sdo;
  wire logic   rdc_pin  = src ? h_casc : rdc;

  adc_serial_readout_port #(.HALF_CYCLES(8'h01)) u_adc_serial_readout_port (
    .CLK(clk), .NRST(nrst), .CLOCK_SOURCE_SELECT(src), .PORT_KIND_SELECT(kind),
    .READ_TIMING_OR_CASCADE_IN(rdc_pin), .CLOCK_INVERT(inv), .CS_N(h_cs_n),
    .RD_N(h_rd_n), .SCLK_IN(sclk_pin), .SCLK_OUT(sclk_out), .SCLK_OE_N(sclk_oe_n),
    .SYNC_OUT(sync), .SERIAL_RESULT_OUT(sdo), .SERIAL_RESULT_OE_N(sdo_oe_n),
    .BUSY(busy), .INCOMPLETE_READ_FLAG(rderr), .CORE_BUSY(cbusy),
    .CORE_RESULT_VALID(cvalid), .CORE_RESULT(cres), .CORE_RESULT_READY(cready));
  adc_host_model u_adc_host_model (
    .clk(clk), .sclk_pin(sclk_pin), .sdo_pin(sdo_pin), .sync(sync), .inv(inv),
    .sclk(h_sclk), .cs_n(h_cs_n), .rd_n(h_rd_n), .casc(h_casc));

  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Tracks the data line, error pulses and buffer refusals.
  always @(posedge clk) begin
    if (!sdo_oe_n) sdo_last <= sdo;
    if (rderr === 1'b1) pulses <= pulses + 1;
    if (cready === 1'b0) saw_full <= 1'b1;
  end

  // Expected stream of a chained read: ours, then the upstream word.
  function automatic logic [31:0] chain_word(input logic [15:0] a, input logic [15:0] b);
    return {a, b};
  endfunction

  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t flag %b expected %b", $time, g, e);
    end
  endtask

  // Waits n edges, then steps 1 ns past the last one.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Offers one word and holds it until the port takes it.
  // Valid stays up when another word follows at once.
  task automatic offer(input logic [15:0] v, input logic more);
    cvalid = 1'b1;
    cres = v;
    @(posedge clk);
    while (cready !== 1'b1) @(posedge clk);
    #1;
    if (!more) cvalid = 1'b0;
  endtask

  task automatic wait_words(input int n);
    for (int t = 0; t < 2000 && u_adc_host_model.mq.size() < n; t++) @(posedge clk);
    #1 check_word(u_adc_host_model.mq.size(), n);
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    #3000000;
    failures++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {nrst, src, rdc, inv, cbusy, cvalid, sdo_last, saw_full} = '0;
    kind = 1'b1;
    cres = 16'h0000;
    {failures, n_checks, pulses} = '0;
    void'($urandom(32'hd8c9));
    repeat (3) @(posedge clk);
    check_word(32'({sclk_out, sclk_oe_n, sync, sdo, sdo_oe_n, busy, rderr, cready}),
               32'h0000_0049);
    #1 nrst = 1'b1;
    u_adc_host_model.select(1'b0, 1'b0);
    // Master: both read timings and both polarities.
    for (int m = 0; m < 4; m++) begin
      rdc = m[0];
      inv = m[1];
      step(8);
      u_adc_host_model.clear();
      for (int i = 0; i < 4; i++) w[i] = 16'($urandom);
      w[3] = 16'h8001;
      check_bit(sclk_oe_n, 1'b0);
      if (!rdc) begin
        saw_full = 1'b0;
        for (int i = 0; i < 4; i++) offer(w[i], i < 3);
        step(2);
        check_bit(busy, 1'b1);
      end else begin
        offer(w[0], 1'b0);
        step(4);
        cbusy = 1'b1;
        step(40);
        cbusy = 1'b0;
      end
      wait_words(rdc ? 1 : 4);
      for (int i = 0; i < (rdc ? 1 : 4); i++)
        check_word(u_adc_host_model.mq[i], w[i]);
      if (!rdc) begin
        check_bit(saw_full, 1'b1);
        step(6);
        check_bit(busy, 1'b0);
      end
    end
    // Slave read after conversion, chained with an upstream word.
    u_adc_host_model.select(1'b1, 1'b1);
    src = 1'b1;
    w[0] = 16'($urandom);
    w[1] = 16'($urandom);
    cbusy = 1'b1;
    step(8);
    offer(w[0], 1'b0);
    step(4);
    cbusy = 1'b0;
    step(6);
    check_bit(sclk_oe_n, 1'b1);
    u_adc_host_model.slave_read(3, 16'h0000, got);
    u_adc_host_model.select(1'b0, 1'b1);
    step(6);
    check_bit(sdo_oe_n, 1'b1);
    u_adc_host_model.select(1'b0, 1'b0);
    step(6);
    check_bit(sdo_oe_n, 1'b0);
    u_adc_host_model.slave_read(32, w[1], got);
    check_word(got, chain_word(w[0], w[1]));
    u_adc_host_model.select(1'b1, 1'b1);
    step(6);
    // Slave read during conversion: partial read, then a complete one.
    for (int e = 0; e < 2; e++) begin
      w[0] = 16'($urandom);
      offer(w[0], 1'b0);
      step(4);
      u_adc_host_model.select(1'b0, 1'b0);
      cbusy = 1'b1;
      step(4);
      pulses = 0;
      u_adc_host_model.slave_read(e ? 16 : 5, 16'h0000, got);
      check_word(got, e ? 32'(w[0]) : 32'(w[0] >> 11));
      step(e ? 140 : 1);
      cbusy = 1'b0;
      step(8);
      check_word(pulses, e ? 0 : 1);
      u_adc_host_model.select(1'b1, 1'b1);
      step(4);
    end
    // Serial port switched off releases the clock and data outputs.
    kind = 1'b0;
    src = 1'b0;
    u_adc_host_model.select(1'b0, 1'b0);
    step(8);
    check_word(32'({sclk_oe_n, sdo_oe_n}), 32'h0000_0003);
    summarize();
  end
endmodule
`default_nettype wire
